// ===== countdown_timer_regs.vh
`ifndef COUNTDOWN_TIMER_REGS_VH
`define COUNTDOWN_TIMER_REGS_VH
// ****************************************************************
// register map (byte address = index * 4)
// ****************************************************************
`define IDX_TICK_CONFIG      8'h2A
`define IDX_CONTROL          8'h2B
`define IDX_PRESET           8'h2C
`define IDX_STATUS           8'h30
`define IDX_MASK             8'h31
`define IDX_COUNT            8'h32
// ****************************************************************
// field positions
// ****************************************************************
`define FLD_AUTO_RELOAD      5
`define FLD_HALT_RX_END      3
`define FLD_HALT_RX_FIRST    2
`define FLD_LAUNCH_TX_END    1
`define FLD_LAUNCH_TX_FIRST  0
`define FLD_EXPIRED          0
`define FLD_RUNNING          1
// ****************************************************************
// reset values and limits
// ****************************************************************
`define RST_TICK_CONFIG      8'h07
`define RST_CONTROL          8'h06
`define RST_PRESET           8'h0A
`define MAX_EXPONENT         5'h15
`define EXP_WIDTH            22
`endif

// ===== tick_prescaler.v
`timescale 1ns/1ps
// ****************************************************************
// power-of-two tick divider
// ****************************************************************
module tick_prescaler (
   input  wire       mclk_in,
   input  wire       reset_in,
   input  wire       clear_in,
   input  wire [4:0] exponent_in,
   output reg        tick_out
);
   reg  [21:0] divide_count;   // free running divider
   wire [21:0] tick_mask;      // low bits that must all be set
   // exponent zero gives a tick every clock; first tick 2^exponent cycles after clear
   assign tick_mask = (22'h000001 << exponent_in) - 22'h000001;
   // count and strobe when the low exponent bits wrap
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         divide_count <= 22'h000000;
         tick_out     <= 1'b0;
      end else if (clear_in) begin
         divide_count <= 22'h000000;
         tick_out     <= (tick_mask == 22'h000000);
      end else begin
         divide_count <= divide_count + 22'h000001;
         // look one count ahead so the registered strobe is not a cycle late
         tick_out     <= (((divide_count + 22'h000001) & tick_mask) == tick_mask);
      end
   end
endmodule

// ===== sticky_event_bit.v
`timescale 1ns/1ps
// ****************************************************************
// sticky status bit, set wins over clear
// ****************************************************************
module sticky_event_bit (
   input  wire mclk_in,
   input  wire reset_in,
   input  wire set_in,
   input  wire clear_in,
   output reg  flag_out
);
   // hold until read, new event beats the clearing read
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         flag_out <= 1'b1;
      end else if (clear_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule

// ===== rf_frame_countdown_timer.v
// Overview of operation
// - prescale exponent accepted from zero to 21
// - tick rate is clock over two^exponent
// - auto reload bit reloads preset at zero
// - without reload, stop at zero, flag expiry
// - control bit 3 halts at receive end
// - control bit 2 halts at first rx bit
// - control bit 1 launches at transmit end
// - control bit 0 launches at first tx bit
// - reset values 07h and 06h
// - start loads preset; zero preset blocks start
`timescale 1ns/1ps
`include "countdown_timer_regs.vh"
module rf_frame_countdown_timer (
   input  wire        mclk_in,
   input  wire        reset_in,
   // wishbone slave
   input  wire        wb_cyc_in,
   input  wire        wb_stb_in,
   input  wire        wb_we_in,
   input  wire [9:0]  wb_adr_in,
   input  wire [3:0]  wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output reg  [31:0] wb_dat_out,
   output reg         wb_ack_out,
   // rf frame events, one cycle pulses
   input  wire        tx_first_bit_in,
   input  wire        tx_end_in,
   input  wire        rx_first_bit_in,
   input  wire        rx_end_in,
   // status outputs
   output reg         irq_out,
   output reg         running_out,
   output reg  [7:0]  count_out
);
   // ****************************************************************
   // registers
   // ****************************************************************
   reg  [7:0] timer_tick_config;         // exponent and reload bit
   reg  [7:0] timer_start_stop_control;  // launch and halt enables
   reg  [7:0] countdown_preset;          // start value
   reg  [1:0] irq_mask;                  // interrupt mask
   reg        running;                   // timer active
   reg  [7:0] count;                     // current count
   wire       countdown_expired_flag;    // sticky expiry
   wire       stopped_flag;              // sticky stop by rx event
   wire [1:0] pending_request_reg;       // status layout
   wire [4:0] tick_divide_exponent;
   wire       auto_reload_enable;
   wire       halt_on_receive_end;
   wire       halt_on_receive_first_bit;
   wire       launch_on_transmit_end;
   wire       launch_on_transmit_first_bit;
   wire       tick;                      // prescaled enable
   wire       launch;                    // start or restart
   wire       halt;                      // rx stop event
   wire       expire;                    // reached zero, no reload
   wire       halt_hit;                  // halt while running
   wire       bus_req;                   // new bus access
   wire       bus_wr;                    // write strobe
   wire       status_rd;                 // read of status clears it
   wire [7:0] reg_index;                 // word index
   // ****************************************************************
   // field decode
   // ****************************************************************
   assign tick_divide_exponent         = timer_tick_config[4:0];
   assign auto_reload_enable           = timer_tick_config[`FLD_AUTO_RELOAD];
   assign halt_on_receive_end          = timer_start_stop_control[`FLD_HALT_RX_END];
   assign halt_on_receive_first_bit    = timer_start_stop_control[`FLD_HALT_RX_FIRST];
   assign launch_on_transmit_end       = timer_start_stop_control[`FLD_LAUNCH_TX_END];
   assign launch_on_transmit_first_bit = timer_start_stop_control[`FLD_LAUNCH_TX_FIRST];
   assign reg_index = wb_adr_in[9:2];
   assign bus_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign bus_wr    = bus_req & wb_we_in & wb_sel_in[0];
   assign status_rd = bus_req & ~wb_we_in & (reg_index == `IDX_STATUS);
   // ****************************************************************
   // start and stop events
   // ****************************************************************
   // launch requests, reloaded even when already running
   assign launch = ((launch_on_transmit_first_bit & tx_first_bit_in) |
                    (launch_on_transmit_end & tx_end_in)) &
                   (countdown_preset != 8'h00);
   assign halt   = (halt_on_receive_first_bit & rx_first_bit_in) |
                   (halt_on_receive_end & rx_end_in);
   assign expire = running & tick & ~launch & ~halt & (count == 8'h01) &
                   ~auto_reload_enable;
   assign halt_hit = running & halt & ~launch;
   // ****************************************************************
   // prescaler, restarted with each launch
   // ****************************************************************
   tick_prescaler u_prescaler (
      .mclk_in     (mclk_in),
      .reset_in    (reset_in),
      .clear_in    (launch),
      .exponent_in (tick_divide_exponent),
      .tick_out    (tick)
   );
   // ****************************************************************
   // countdown engine
   // ****************************************************************
   // launch beats halt; halt beats counting
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         running <= 1'b0;
         count   <= 8'h00;
      end else if (launch) begin
         running <= 1'b1;
         count   <= countdown_preset;
      end else if (halt) begin
         running <= 1'b0;
      end else if (running & tick) begin
         if (count == 8'h01) begin
            if (auto_reload_enable) begin
               count <= countdown_preset;
            end else begin
               count   <= 8'h00;
               running <= 1'b0;
            end
         end else begin
            count <= count - 8'h01;
         end
      end
   end
   // ****************************************************************
   // interrupt status
   // ****************************************************************
   sticky_event_bit u_expired_bit (
      .mclk_in  (mclk_in),
      .reset_in (reset_in),
      .set_in   (expire),
      .clear_in (status_rd),
      .flag_out (countdown_expired_flag)
   );
   sticky_event_bit u_stopped_bit (
      .mclk_in  (mclk_in),
      .reset_in (reset_in),
      .set_in   (halt_hit),
      .clear_in (status_rd),
      .flag_out (stopped_flag)
   );
   assign pending_request_reg = {stopped_flag, countdown_expired_flag};
   // ****************************************************************
   // register writes
   // ****************************************************************
   // upper unused bits are stored as written, except in the mask; software keeps them zero
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         timer_tick_config        <= `RST_TICK_CONFIG;
         timer_start_stop_control <= `RST_CONTROL;
         countdown_preset         <= `RST_PRESET;
         irq_mask                 <= 2'h0;
      end else if (bus_wr) begin
         if (reg_index == `IDX_TICK_CONFIG) begin
            // exponent above the top value is clamped
            if (wb_dat_in[4:0] > `MAX_EXPONENT) begin
               timer_tick_config <= {wb_dat_in[7:5], `MAX_EXPONENT};
            end else begin
               timer_tick_config <= wb_dat_in[7:0];
            end
         end else if (reg_index == `IDX_CONTROL) begin
            timer_start_stop_control <= wb_dat_in[7:0];
         end else if (reg_index == `IDX_PRESET) begin
            countdown_preset <= wb_dat_in[7:0];
         end else if (reg_index == `IDX_MASK) begin
            irq_mask <= wb_dat_in[1:0];
         end
      end
   end
   // ****************************************************************
   // bus answer and outputs
   // ****************************************************************
   // one cycle ack, read data registered in the same cycle as the ack, unmapped read zero
   always @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         wb_ack_out  <= 1'b0;
         wb_dat_out  <= 32'h00000000;
         irq_out     <= 1'b0;
         running_out <= 1'b0;
         count_out   <= 8'h00;
      end else begin
         wb_ack_out  <= bus_req;
         irq_out     <= |(pending_request_reg & irq_mask);
         running_out <= running;
         count_out   <= count;
         if (bus_req & ~wb_we_in) begin
            if (reg_index == `IDX_TICK_CONFIG) begin
               wb_dat_out <= {24'h000000, timer_tick_config};
            end else if (reg_index == `IDX_CONTROL) begin
               wb_dat_out <= {24'h000000, timer_start_stop_control};
            end else if (reg_index == `IDX_PRESET) begin
               wb_dat_out <= {24'h000000, countdown_preset};
            end else if (reg_index == `IDX_STATUS) begin
               wb_dat_out <= {29'h00000000, running, pending_request_reg};
            end else if (reg_index == `IDX_MASK) begin
               wb_dat_out <= {30'h00000000, irq_mask};
            end else if (reg_index == `IDX_COUNT) begin
               wb_dat_out <= {24'h000000, count};
            end else begin
               wb_dat_out <= 32'h00000000;
            end
         end
      end
   end
endmodule

// ===== timer_chk.sv
`timescale 1ns/1ps
// ****************************************************
// port checks for the countdown timer
// ****************************************************
module timer_chk (
   input wire        mclk_in,
   input wire        reset_in,
   input wire        wb_cyc_in,
   input wire        wb_stb_in,
   input wire        wb_ack_out,
   input wire [31:0] wb_dat_out,
   input wire        tx_first_bit_in,
   input wire        tx_end_in,
   input wire        rx_first_bit_in,
   input wire        rx_end_in,
   input wire        running_out,
   input wire [7:0]  count_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);
   // a bus request the slave has not yet answered
   sequence s_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   // a launch pulse two edges back
   sequence s_launch;
      $past(tx_first_bit_in, 2) || $past(tx_end_in, 2);
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_out) else $error("ack late");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   a_ack_stray: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
      else $error("ack without request");
   a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_launch_cause: assert property ($rose(running_out) |-> s_launch)
      else $error("start without launch");
   a_start_nonzero: assert property ($rose(running_out) |-> count_out != 8'h00)
      else $error("start with zero count");
   a_halt_cause: assert property ($fell(running_out) |-> count_out == 8'h00
      || $past(rx_first_bit_in, 2) || $past(rx_end_in, 2)) else $error("stop without cause");
   a_zero_idle: assert property (count_out == 8'h00 |-> !running_out)
      else $error("running at zero");
   a_held_idle: assert property ($changed(count_out) |-> running_out || $past(running_out))
      else $error("count moved while stopped");
   a_dec_one: assert property (running_out && $past(running_out)
      && !$past(tx_first_bit_in, 2) && !$past(tx_end_in, 2)
      && count_out < $past(count_out) |-> count_out == $past(count_out) - 8'h01)
      else $error("step not one");
endmodule
bind rf_frame_countdown_timer timer_chk u_chk (
   .mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .tx_first_bit_in(tx_first_bit_in),
   .tx_end_in(tx_end_in), .rx_first_bit_in(rx_first_bit_in), .rx_end_in(rx_end_in),
   .running_out(running_out), .count_out(count_out));

// ===== tb_rf_frame_countdown_timer.sv
`timescale 1ns/1ps
`include "countdown_timer_regs.vh"
module tb_rf_frame_countdown_timer;
   logic        mclk_in;    // bench clock
   logic        reset_in;   // async reset
   logic        cyc;        // bus cycle
   logic        stb;        // bus strobe
   logic        we;         // write direction
   logic [9:0]  adr;        // byte address
   logic [31:0] dat;        // write data
   logic [3:0]  ev;         // rx_end, rx_first, tx_end, tx_first
   logic [7:0]  q;          // last read byte
   int          n;          // running cycle count
   int          n_mismatch; // mismatches
   int          cmp_count;  // comparisons
   wire  [31:0] wb_dat_out; // read data
   wire         wb_ack_out; // bus answer
   wire         irq_out;    // interrupt level
   wire         running_out;
   wire  [7:0]  count_out;
   rf_frame_countdown_timer u_dut (
      .mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .tx_first_bit_in(ev[0]),
      .tx_end_in(ev[1]), .rx_first_bit_in(ev[2]), .rx_end_in(ev[3]), .irq_out(irq_out),
      .running_out(running_out), .count_out(count_out));
   // ****************************************************
   // bench tasks
   // ****************************************************
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // one classic cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge mclk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat <= {24'h000000, d};
      do begin
         @(posedge mclk_in);
         k++;
      end while (wb_ack_out !== 1'b1 && k < 20);
      q = wb_dat_out[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20) n_mismatch++;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(q, exp);
   endtask
   // one-cycle frame event
   task automatic pulse(input int i);
      @(posedge mclk_in);
      ev <= 4'h1 << i;
      @(posedge mclk_in);
      ev <= 4'h0;
   endtask
   // count cycles with running_out high
   task automatic run_len(input int e);
      n = 0;
      @(posedge mclk_in);
      repeat (200) begin
         @(posedge mclk_in);
         if (running_out === 1'b1) n++;
      end
      chk(8'(n), 8'(e));
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ****************************************************
   // clock, watchdog, tests
   // ****************************************************
   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      logic [7:0] ri [7] = '{`IDX_TICK_CONFIG, `IDX_CONTROL, `IDX_PRESET, `IDX_MASK,
                             `IDX_STATUS, `IDX_COUNT, 8'h3F};
      logic [7:0] rv [7] = '{`RST_TICK_CONFIG, `RST_CONTROL, `RST_PRESET, 8'h00,
                             8'h00, 8'h00, 8'h00};
      reset_in = 1'b1;
      {cyc, stb, we, adr, dat, ev} = '0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (10) @(posedge mclk_in);
      reset_in <= 1'b0;
      foreach (ri[i]) rd(ri[i], rv[i]);
      wb(1'b1, `IDX_TICK_CONFIG, 8'h1F);
      rd(`IDX_TICK_CONFIG, {3'b000, `MAX_EXPONENT});
      // exponent 2, preset 3, expiry unmasked; upper bits kept zero
      wb(1'b1, `IDX_TICK_CONFIG, 8'h02);
      wb(1'b1, `IDX_CONTROL, 8'h02);
      wb(1'b1, `IDX_PRESET, 8'h03);
      wb(1'b1, `IDX_MASK, 8'h01);
      pulse(1);
      run_len(12);
      chk(8'(irq_out), 8'h01);
      rd(`IDX_STATUS, 8'h01);
      repeat (2) @(posedge mclk_in);
      chk(8'(irq_out), 8'h00);
      // masked expiry at exponent 0
      wb(1'b1, `IDX_MASK, 8'h00);
      wb(1'b1, `IDX_TICK_CONFIG, 8'h00);
      pulse(1);
      run_len(3);
      chk(8'(irq_out), 8'h00);
      rd(`IDX_STATUS, 8'h01);
      // auto reload, then halt on first received bit
      wb(1'b1, `IDX_TICK_CONFIG, 8'h20);
      wb(1'b1, `IDX_CONTROL, 8'h06);
      pulse(1);
      run_len(200);
      rd(`IDX_STATUS, 8'h04);
      pulse(2);
      run_len(0);
      rd(`IDX_STATUS, 8'h02);
      // preset change waits for the next launch
      wb(1'b1, `IDX_TICK_CONFIG, 8'h07);
      wb(1'b1, `IDX_PRESET, 8'h05);
      pulse(1);
      wb(1'b1, `IDX_PRESET, 8'h09);
      rd(`IDX_COUNT, 8'h05);
      pulse(1);
      rd(`IDX_COUNT, 8'h09);
      wb(1'b1, `IDX_CONTROL, 8'h09);
      wb(1'b1, `IDX_PRESET, 8'h0C);
      pulse(0);
      rd(`IDX_COUNT, 8'h0C);
      pulse(2);
      rd(`IDX_STATUS, 8'h04);
      pulse(3);
      rd(`IDX_STATUS, 8'h02);
      // launches disabled, then a zero preset
      wb(1'b1, `IDX_CONTROL, 8'h00);
      pulse(0);
      pulse(1);
      run_len(0);
      wb(1'b1, `IDX_CONTROL, 8'h01);
      wb(1'b1, `IDX_PRESET, 8'h00);
      pulse(0);
      run_len(0);
      report_and_stop();
   end
endmodule
